/* hw/smr_consts.svh */
`ifndef SMR_CONSTS_SVH
`define SMR_CONSTS_SVH
// Bank address codes that pick the register on a mode-register-set command
`define SMR_MODE_REG_TWO_BA 3'h2
`define SMR_MODE_REG_THREE_BA 3'h3
// Field positions on the address pins, register two
`define SMR_PAS_LSB 0
`define SMR_CAS_LAT_LSB 3
`define SMR_SR_TEMP_BIT 7
`define SMR_RTT_WR_LSB 9
// Field positions on the address pins, register three
`define SMR_MPAT_PAGE_LSB 0
`define SMR_MPAT_EN_BIT 2
// Layout of the synchronised pin vector
`define SMR_PIN_ODT 23
`define SMR_PIN_CS 22
`define SMR_PIN_RAS 21
`define SMR_PIN_CAS 20
`define SMR_PIN_WE 19
`define SMR_PIN_BA_LSB 16
// Reset values of the stored fields
`define SMR_PAS_RST 3'h0
`define SMR_CAS_LAT_RST 3'h0
`define SMR_SR_TEMP_RST 1'h0
`define SMR_RTT_WR_RST 2'h0
`define SMR_MPAT_EN_RST 1'h0
`define SMR_MPAT_PAGE_RST 2'h0
// Timing
`define SMR_CLK_PERIOD_NS 20
`define SMR_REFI_NS 7800
`define SMR_REFI_CYC (`SMR_REFI_NS / `SMR_CLK_PERIOD_NS)
`define SMR_TERM_HOLD_CYC 4
`endif

/* hw/smr_pkg.sv */
package smr_pkg;
  // Termination strength chosen for the data pins
  typedef enum logic [1:0] {SMR_RTT_OFF, SMR_RTT_NOM, SMR_RTT_WR} smr_rtt_t;

  // Whole state of the top module
  typedef struct packed {
    logic [23:0] pin_s1; // First sync stage
    logic [23:0] pin_s2; // Second sync stage
    logic [2:0] pas; // Partial array range
    logic [2:0] cas_lat; // Write latency code
    logic sr_temp; // Self-refresh temperature option
    logic [1:0] rtt_wr; // Write termination code
    logic mpat_en; // Pattern register enable
    logic [1:0] mpat_page; // Pattern page, zero when disabled
    logic [5:0] tot_lat; // Total write latency
    logic int_wr; // Internal write pulse
    logic int_rd; // Internal read pulse
    logic wdata_exp; // First data bit expected
    logic mpat_vld; // Pattern read pulse
    logic [7:0] mpat_data; // Pattern read data
    logic [6:0] win; // Write termination window
    smr_rtt_t rtt; // Termination select
    logic [8:0] sr_cnt; // Self-refresh interval count
    logic sr_tick; // Self-refresh pulse
    logic [7:0] keep; // Banks kept in self-refresh
  } smr_state_t;
endpackage

/* hw/smr_pulse_delay.sv */
`timescale 1ns/10ps
// Delays single-cycle pulses by a run-time count; pipelined, so
// back-to-back pulses each come out on their own
module smr_pulse_delay #(
  parameter int DEPTH = 63
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic pulse_in,
  input wire logic [5:0] delay_in,
  output logic pulse_out
);
  logic [DEPTH:0] sh_r; // Bit k holds the pulse seen k+1 cycles ago
  logic [DEPTH:0] sh_nxt;

  // Shift in the new pulse each cycle
  always_comb begin
    sh_nxt = {sh_r[DEPTH-1:0], pulse_in};
  end

  // Tap zero is the live input, so a zero delay passes straight through
  always_comb begin
    pulse_out = sh_nxt[delay_in];
  end

  // Line register
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sh_r <= '0;
    end else begin
      sh_r <= sh_nxt;
    end
  end
endmodule

/* hw/smr_mode_regs.sv */
`timescale 1ns/10ps
`include "smr_consts.svh"
// Overview of operation
// - Command with bank code two loads register two
// - Command with bank code three loads register three
// - Pattern disabled means page bits ignored
// - Pattern enabled reads return predefined pattern on page zero, zero on other pages
// - Write latency code from address bits 3-5
// - Data expected whole latency cycles after write
// - Total write latency is additive plus write
// - Write termination from bits 9-10, switched automatically
// - Write termination applies with nominal disabled
// - Write leveling uses nominal termination only
// - Self-refresh may drop banks outside range
// - Without self-refresh all banks are kept
// - Bit 7 off gives normal refresh rate
// - Bit 7 on doubles internal refresh rate
// - Read and write held for additive latency
module smr_mode_regs
  import smr_pkg::*;
#(
  parameter logic [5:0] CAS_BASE = 6'h05, // Cycles for latency code zero
  parameter logic [7:0] MPAT_PATTERN = 8'h55 // Page zero read pattern
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic cs_n_in,
  input wire logic ras_n_in,
  input wire logic cas_n_in,
  input wire logic we_n_in,
  input wire logic [2:0] ba_in,
  input wire logic [15:0] addr_in,
  input wire logic odt_in,
  input wire logic [4:0] additive_latency_in,
  input wire logic rtt_nom_en_in,
  input wire logic write_level_in,
  input wire logic selfrefresh_in,
  output logic [2:0] partial_array_selfrefresh_out,
  output logic [2:0] cas_write_latency_out,
  output logic selfrefresh_temp_option_out,
  output logic [1:0] rtt_wr_out,
  output logic multipurpose_pattern_reg_en_out,
  output logic [1:0] multipurpose_pattern_page_out,
  output logic [5:0] total_write_latency_out,
  output logic int_write_out,
  output logic int_read_out,
  output logic wdata_expect_out,
  output logic mpat_valid_out,
  output logic [7:0] mpat_data_out,
  output smr_rtt_t rtt_sel_out,
  output logic sr_tick_out,
  output logic [7:0] bank_keep_out
);
  // Interval counts; the doubled rate simply halves the count
  localparam logic [8:0] REFI_FULL = 9'(`SMR_REFI_CYC); // Normal interval
  localparam logic [8:0] REFI_HALF = 9'(`SMR_REFI_CYC / 2); // Doubled rate

  smr_state_t s; // Registered state
  smr_state_t n; // Next state
  logic [23:0] pins; // Raw pins, not yet synchronised
  logic cmd_mrs; // Register-set command seen
  logic cmd_wr; // External write
  logic cmd_rd; // External read
  logic [2:0] cmd_ba; // Bank code of the command
  logic [15:0] cmd_a; // Address of the command
  logic [5:0] cas_cyc; // Write latency in cycles
  logic wr_al; // Write after additive hold
  logic rd_al; // Read after additive hold
  logic wr_data; // Write after full latency

  // Gather every pin into one vector so one sync pair covers them all
  // Pin skew is hidden behind the two stages, at two cycles of latency
  assign pins = {odt_in, cs_n_in, ras_n_in, cas_n_in, we_n_in, ba_in, addr_in};

  // Decode only from the second sync stage
  always_comb begin
    cmd_ba = s.pin_s2[`SMR_PIN_BA_LSB +: 3];
    cmd_a = s.pin_s2[15:0];
    cmd_mrs = !s.pin_s2[`SMR_PIN_CS] && !s.pin_s2[`SMR_PIN_RAS]
      && !s.pin_s2[`SMR_PIN_CAS] && !s.pin_s2[`SMR_PIN_WE];
    cmd_wr = !s.pin_s2[`SMR_PIN_CS] && s.pin_s2[`SMR_PIN_RAS]
      && !s.pin_s2[`SMR_PIN_CAS] && !s.pin_s2[`SMR_PIN_WE];
    cmd_rd = !s.pin_s2[`SMR_PIN_CS] && s.pin_s2[`SMR_PIN_RAS]
      && !s.pin_s2[`SMR_PIN_CAS] && s.pin_s2[`SMR_PIN_WE];
    cas_cyc = {3'h0, s.cas_lat} + CAS_BASE;
  end

  // Additive hold lets a command follow activate at once
  smr_pulse_delay #(.DEPTH(63)) u_wr_hold (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .pulse_in(cmd_wr),
    .delay_in({1'b0, additive_latency_in}),
    .pulse_out(wr_al)
  );

  smr_pulse_delay #(.DEPTH(63)) u_rd_hold (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .pulse_in(cmd_rd),
    .delay_in({1'b0, additive_latency_in}),
    .pulse_out(rd_al)
  );

  // Whole cycles only; no half-cycle step exists here
  smr_pulse_delay #(.DEPTH(63)) u_wr_data (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .pulse_in(wr_al),
    .delay_in(cas_cyc),
    .pulse_out(wr_data)
  );

  // Next-state logic for everything the block holds
  always_comb begin
    n = s;
    n.pin_s1 = pins;
    n.pin_s2 = s.pin_s1;
    // Spare bits are not checked; the controller keeps them zero
    if (cmd_mrs && cmd_ba == `SMR_MODE_REG_TWO_BA) begin
      n.pas = cmd_a[`SMR_PAS_LSB +: 3];
      n.cas_lat = cmd_a[`SMR_CAS_LAT_LSB +: 3];
      n.sr_temp = cmd_a[`SMR_SR_TEMP_BIT];
      n.rtt_wr = cmd_a[`SMR_RTT_WR_LSB +: 2];
    end else if (cmd_mrs && cmd_ba == `SMR_MODE_REG_THREE_BA) begin
      n.mpat_en = cmd_a[`SMR_MPAT_EN_BIT];
      // Page bits are dropped while the pattern is off
      n.mpat_page = cmd_a[`SMR_MPAT_EN_BIT] ? cmd_a[`SMR_MPAT_PAGE_LSB +: 2]
        : 2'h0;
    end
    // Otherwise every field holds its last value
    n.tot_lat = {1'b0, additive_latency_in} + cas_cyc;
    n.int_wr = wr_al;
    n.wdata_exp = wr_data;
    // Reads go to the array or to the pattern, never both
    n.int_rd = rd_al && !s.mpat_en;
    n.mpat_vld = rd_al && s.mpat_en;
    if (rd_al && s.mpat_en) begin
      n.mpat_data = (s.mpat_page == 2'h0) ? MPAT_PATTERN : 8'h00;
    end
    // Termination window covers the write up to the end of its data
    if (cmd_wr) begin
      n.win = {1'b0, s.tot_lat} + 7'(`SMR_TERM_HOLD_CYC);
    end else if (s.win != 7'h00) begin
      n.win = s.win - 7'h01;
    end
    // Odt passes the same sync stages as the command, keeping them aligned
    // Termination select
    if (!s.pin_s2[`SMR_PIN_ODT]) begin
      n.rtt = SMR_RTT_OFF;
    end else if (write_level_in) begin
      // No dynamic switching while leveling
      n.rtt = rtt_nom_en_in ? SMR_RTT_NOM : SMR_RTT_OFF;
    end else if (s.win != 7'h00 && s.rtt_wr != 2'h0) begin
      // Applies even with nominal termination off
      n.rtt = SMR_RTT_WR;
    end else begin
      n.rtt = rtt_nom_en_in ? SMR_RTT_NOM : SMR_RTT_OFF;
    end
    // Counter restarts on each entry, so the first tick is a full interval late
    // Internal refresh timer runs only in self-refresh
    n.sr_tick = 1'b0;
    if (!selfrefresh_in) begin
      n.sr_cnt = 9'h000;
    end else if (s.sr_cnt >= (s.sr_temp ? REFI_HALF : REFI_FULL) - 9'h001) begin
      n.sr_cnt = 9'h000;
      n.sr_tick = 1'b1;
    end else begin
      n.sr_cnt = s.sr_cnt + 9'h001;
    end
    // Banks kept; outside self-refresh every bank is refreshed
    if (!selfrefresh_in) begin
      n.keep = 8'hff;
    end else begin
      case (s.pas)
        3'h1: n.keep = 8'h0f; // Lower half
        3'h2: n.keep = 8'h03; // Lower quarter
        3'h3: n.keep = 8'h01; // Lower eighth
        3'h4: n.keep = 8'hfc; // Upper three quarters
        3'h5: n.keep = 8'hf0; // Upper half
        3'h6: n.keep = 8'hc0; // Upper quarter
        3'h7: n.keep = 8'h80; // Upper eighth
        default: n.keep = 8'hff; // Full array
      endcase
    end
  end

  // State register
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      // Clear everything, then load the field defaults
      s <= '0;
      s.pas <= `SMR_PAS_RST;
      s.cas_lat <= `SMR_CAS_LAT_RST;
      s.sr_temp <= `SMR_SR_TEMP_RST;
      s.rtt_wr <= `SMR_RTT_WR_RST;
      s.mpat_en <= `SMR_MPAT_EN_RST;
      s.mpat_page <= `SMR_MPAT_PAGE_RST;
      s.tot_lat <= CAS_BASE;
      s.rtt <= SMR_RTT_OFF;
      s.keep <= 8'hff;
    end else begin
      s <= n;
    end
  end

  // Outputs straight from the state register
  assign partial_array_selfrefresh_out = s.pas;
  assign cas_write_latency_out = s.cas_lat;
  assign selfrefresh_temp_option_out = s.sr_temp;
  assign rtt_wr_out = s.rtt_wr;
  assign multipurpose_pattern_reg_en_out = s.mpat_en;
  assign multipurpose_pattern_page_out = s.mpat_page;
  assign total_write_latency_out = s.tot_lat;
  assign int_write_out = s.int_wr;
  assign int_read_out = s.int_rd;
  assign wdata_expect_out = s.wdata_exp;
  assign mpat_valid_out = s.mpat_vld;
  assign mpat_data_out = s.mpat_data;
  assign rtt_sel_out = s.rtt;
  assign sr_tick_out = s.sr_tick;
  assign bank_keep_out = s.keep;

  // Checks on the block's own behaviour
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  a_two_load:
  assert property (cmd_mrs && cmd_ba == `SMR_MODE_REG_TWO_BA |=>
    s.pas == $past(cmd_a[2:0]) && s.rtt_wr == $past(cmd_a[10:9]))
    else $error("register two not loaded");

  a_three_load:
  assert property (cmd_mrs && cmd_ba == `SMR_MODE_REG_THREE_BA |=>
    s.mpat_en == $past(cmd_a[2]))
    else $error("register three not loaded");

  a_page_ignored:
  assert property (!s.mpat_en |-> s.mpat_page == 2'h0)
    else $error("page bits used while pattern disabled");

  a_pattern_read:
  assert property (rd_al && s.mpat_en && s.mpat_page == 2'h0 |=>
    s.mpat_vld && !s.int_rd && s.mpat_data == MPAT_PATTERN)
    else $error("pattern not returned");

  a_latency_code:
  assert property (cmd_mrs && cmd_ba == `SMR_MODE_REG_TWO_BA |=>
    cas_write_latency_out == $past(cmd_a[5:3]))
    else $error("latency code from wrong bits");

  a_total_sum:
  assert property ($stable(additive_latency_in) && $stable(s.cas_lat) |=>
    s.tot_lat == {1'b0, $past(additive_latency_in)} + {3'h0, $past(s.cas_lat)} + CAS_BASE)
    else $error("total latency is not the sum");

  a_array_read:
  assert property (rd_al && !s.mpat_en |=> s.int_rd && !s.mpat_vld)
    else $error("read not sent to the array");

  a_timer_idle:
  assert property (!selfrefresh_in |=> s.sr_cnt == 9'h000 && !s.sr_tick)
    else $error("refresh timer runs outside self-refresh");

  a_hold_zero:
  assert property (cmd_wr && additive_latency_in == 5'h00 |=> s.int_wr)
    else $error("write not issued with zero hold");

  a_wr_term:
  assert property (s.pin_s2[`SMR_PIN_ODT] && !write_level_in && !rtt_nom_en_in
    && s.win != 7'h00 && s.rtt_wr != 2'h0 |=> s.rtt == SMR_RTT_WR)
    else $error("write termination not applied");

  a_level_nominal:
  assert property (write_level_in |=> s.rtt != SMR_RTT_WR)
    else $error("dynamic termination during leveling");

  a_keep_all:
  assert property (!selfrefresh_in |=> s.keep == 8'hff)
    else $error("banks dropped outside self-refresh");

  a_rate_double:
  assert property (selfrefresh_in && s.sr_temp && $past(s.sr_temp) |->
    s.sr_cnt < REFI_HALF)
    else $error("refresh rate not doubled");

  a_regs_hold:
  assert property (!cmd_mrs |=> $stable(s.pas) && $stable(s.cas_lat)
    && $stable(s.mpat_en) && $stable(s.sr_temp))
    else $error("mode field changed without load");

  c_two_load: cover property (cmd_mrs && cmd_ba == `SMR_MODE_REG_TWO_BA);
  c_pattern: cover property (s.mpat_vld);
  c_wr_term: cover property (s.rtt == SMR_RTT_WR);
  c_fast_tick: cover property (s.sr_tick && s.sr_temp);
  c_level_nom: cover property (write_level_in && s.rtt == SMR_RTT_NOM);
endmodule

/* bench/smr_ctrl_model.sv */
`timescale 1ns/10ps
// Controller stand-in: one command slot per request, deselect otherwise
module smr_ctrl_model (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic go_in, // Request strobe
  input wire logic [1:0] kind_in, // 0 register set, 1 write, 2 read
  input wire logic [2:0] ba_in,
  input wire logic [15:0] addr_in,
  output logic cs_n_out,
  output logic ras_n_out,
  output logic cas_n_out,
  output logic we_n_out,
  output logic [2:0] ba_out,
  output logic [15:0] addr_out
);
  // Idle bank and address pins toggle, so a stale value never passes for a command field
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      {cs_n_out, ras_n_out, cas_n_out, we_n_out} <= 4'hf;
      ba_out <= 3'h0;
      addr_out <= 16'h0000;
    end else if (go_in) begin
      cs_n_out <= 1'b0;
      ras_n_out <= (kind_in != 2'h0);
      cas_n_out <= 1'b0;
      we_n_out <= (kind_in == 2'h2);
      ba_out <= ba_in;
      // Spare bits of register two sent low
      if (kind_in == 2'h0 && ba_in == 3'h2) begin
        addr_out <= addr_in & 16'h06bf;
      // Spare bits of register three sent low
      end else if (kind_in == 2'h0 && ba_in == 3'h3) begin
        addr_out <= addr_in & 16'h0007;
      end else begin
        addr_out <= addr_in;
      end
    end else begin
      cs_n_out <= 1'b1;
      ba_out <= ~ba_out;
      addr_out <= ~addr_out;
    end
  end
endmodule

/* bench/smr_mode_regs_tb_top.sv */
`timescale 1ns/10ps
// Self-checking bench; pulses are matched against timed notes
module smr_mode_regs_tb_top;
  import smr_pkg::*;
  // Expected pulse: {write data, read, pattern} one-hot, cycle, data
  typedef struct packed {logic [2:0] k; logic [31:0] cyc; logic [7:0] d;} smr_note_t;
  localparam logic [5:0] BASE = 6'h05; // Cycles for latency code zero
  localparam logic [7:0] PAT = 8'h55; // Page zero pattern
  localparam int LIMIT = 20000; // Run ceiling in cycles
  localparam int REFI_NORM = 7800 / 20; // Normal refresh interval in cycles
  // Hot external interval, also the doubled internal rate
  localparam int REFI_HOT = 3900 / 20;
  logic ref_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic go = 1'b0;
  logic [1:0] kind = 2'h0;
  logic [2:0] ba = 3'h0;
  logic [15:0] addr = 16'h0000;
  logic odt = 1'b0;
  logic [4:0] al = 5'h00;
  logic nom_en = 1'b0;
  logic wlev = 1'b0;
  logic sref = 1'b0;
  logic cs_n, ras_n, cas_n, we_n, selfrefresh_temp_option, mp_en, iw, ir, wde, mpv, tick;
  logic [2:0] pba, pas, cas_write_latency;
  logic [15:0] paddr;
  logic [1:0] rtt_wr, mp_page;
  logic [5:0] tot;
  logic [7:0] mpd, keep;
  smr_rtt_t rsel;
  int error_cnt = 0;
  int comparisons = 0;
  int cyc = 0;
  int t0, g;
  logic [15:0] a;
  smr_note_t n;
  smr_note_t notes[$];
  logic [7:0] mask_tab [8] = '{8'hff, 8'h0f, 8'h03, 8'h01, 8'hfc, 8'hf0, 8'hc0, 8'h80};

  smr_ctrl_model smr_ctrl_model_inst (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .go_in(go), .kind_in(kind), .ba_in(ba), .addr_in(addr), .cs_n_out(cs_n),
    .ras_n_out(ras_n), .cas_n_out(cas_n), .we_n_out(we_n), .ba_out(pba), .addr_out(paddr));
  smr_mode_regs #(.CAS_BASE(BASE), .MPAT_PATTERN(PAT)) smr_mode_regs_inst (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .cs_n_in(cs_n), .ras_n_in(ras_n),
    .cas_n_in(cas_n), .we_n_in(we_n), .ba_in(pba), .addr_in(paddr), .odt_in(odt),
    .additive_latency_in(al), .rtt_nom_en_in(nom_en), .write_level_in(wlev),
    .selfrefresh_in(sref), .partial_array_selfrefresh_out(pas),
    .cas_write_latency_out(cas_write_latency), .selfrefresh_temp_option_out(selfrefresh_temp_option), .rtt_wr_out(rtt_wr),
    .multipurpose_pattern_reg_en_out(mp_en), .multipurpose_pattern_page_out(mp_page),
    .total_write_latency_out(tot), .int_write_out(iw), .int_read_out(ir),
    .wdata_expect_out(wde), .mpat_valid_out(mpv), .mpat_data_out(mpd),
    .rtt_sel_out(rsel), .sr_tick_out(tick), .bank_keep_out(keep));

  // Clock at 50 MHz
  always #10 ref_clk_in = ~ref_clk_in;

  // Edge counter doubles as the hang guard
  always @(posedge ref_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      error_cnt++;
      stop_test();
    end
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Wait edges, then settle past them
  task automatic wt(input int k);
    repeat (k) @(posedge ref_clk_in);
    #1;
  endtask

  // Send cnt back-to-back commands; t0 is the edge of the first slot
  task automatic issue(input logic [1:0] k, input logic [2:0] b, input logic [15:0] ad,
                       input int cnt);
    @(posedge ref_clk_in);
    go <= 1'b1;
    kind <= k;
    ba <= b;
    addr <= ad;
    repeat (cnt) @(posedge ref_clk_in);
    go <= 1'b0;
    #1 t0 = cyc - cnt + 1;
  endtask

  // Gap between two self-refresh pulses
  task automatic tick_gap(output int gap);
    int s;
    @(posedge tick);
    #1 s = cyc;
    @(posedge tick);
    #1 gap = cyc - s;
  endtask

  // Pulse watcher: oldest note must match kind and cycle, and data for pattern reads
  always @(negedge ref_clk_in) begin
    if (rst_n_in === 1'b1 && (wde === 1'b1 || ir === 1'b1 || mpv === 1'b1)) begin
      if (notes.size() == 0) begin
        check("stray pulse", {wde, ir, mpv}, 0);
      end else begin
        n = notes.pop_front();
        check("pulse kind", {wde, ir, mpv}, n.k);
        check("pulse cycle", cyc, n.cyc);
        if (n.k == 3'b001) check("pattern data", mpd, n.d);
      end
    end
  end

  initial begin
    void'($urandom(4));
    repeat (6) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    wt(2);
    check("latency after reset", tot, BASE);
    check("keep after reset", keep, 8'hff);
    // Register two with random fields, then two writes back to back
    repeat (3) begin
      a = 16'($urandom);
      @(posedge ref_clk_in);
      al <= 5'($urandom_range(3));
      issue(2'h0, 3'h2, a, 1);
      wt(5);
      check("range code", pas, a[2:0]);
      check("write latency code", cas_write_latency, a[5:3]);
      check("temp option", selfrefresh_temp_option, a[7]);
      check("write term code", rtt_wr, a[10:9]);
      check("total latency", tot, al + BASE + a[5:3]);
      issue(2'h1, 3'h0, 16'($urandom), 2);
      notes.push_back({3'b100, t0 + 3 + al + BASE + a[5:3], 8'h00});
      notes.push_back({3'b100, t0 + 4 + al + BASE + a[5:3], 8'h00});
      wt(60);
    end
    // Other bank code leaves register two alone
    issue(2'h0, 3'h1, 16'hffff, 1);
    wt(5);
    check("held latency code", cas_write_latency, a[5:3]);
    // Register three disabled: page ignored, reads go to the array
    issue(2'h0, 3'h3, 16'hfff3, 1);
    wt(5);
    check("pattern enable", mp_en, 1'b0);
    check("page ignored", mp_page, 2'h0);
    issue(2'h2, 3'h0, 16'h0000, 1);
    notes.push_back({3'b010, t0 + 3 + al, 8'h00});
    wt(10);
    // Every pattern page
    for (int p = 0; p < 4; p++) begin
      issue(2'h0, 3'h3, 16'(4 + p), 1);
      wt(5);
      check("page", mp_page, p);
      issue(2'h2, 3'h0, 16'h0000, 1);
      notes.push_back({3'b001, t0 + 3 + al, (p == 0) ? PAT : 8'h00});
      wt(10);
    end
    // Write termination with nominal disabled, zero additive hold
    issue(2'h0, 3'h2, 16'h0200, 1);
    wt(5);
    @(posedge ref_clk_in);
    odt <= 1'b1;
    al <= 5'h00;
    issue(2'h1, 3'h0, 16'h0000, 1);
    notes.push_back({3'b100, t0 + 3 + al + BASE, 8'h00});
    wt(3);
    check("internal write", iw, 1'b1);
    wt(2);
    check("write termination", rsel, SMR_RTT_WR);
    wt(30);
    // Leveling keeps the nominal value only
    @(posedge ref_clk_in);
    nom_en <= 1'b1;
    wlev <= 1'b1;
    issue(2'h1, 3'h0, 16'h0000, 1);
    notes.push_back({3'b100, t0 + 3 + al + BASE, 8'h00});
    wt(5);
    check("leveling termination", rsel, SMR_RTT_NOM);
    wt(30);
    // Loop-off style setup: write termination code zero
    @(posedge ref_clk_in);
    wlev <= 1'b0;
    issue(2'h0, 3'h2, 16'h0000, 1);
    wt(5);
    issue(2'h1, 3'h0, 16'h0000, 1);
    notes.push_back({3'b100, t0 + 3 + al + BASE, 8'h00});
    wt(5);
    check("termination with code zero", rsel, SMR_RTT_NOM);
    wt(30);
    // Each range code in self-refresh; option set before entry
    for (int i = 0; i < 8; i++) begin
      @(posedge ref_clk_in);
      odt <= 1'b0;
      wlev <= 1'b0;
      sref <= 1'b0;
      issue(2'h0, 3'h2, {8'h00, i[0], 4'h0, 3'(i)}, 1);
      wt(5);
      @(posedge ref_clk_in);
      sref <= 1'b1;
      wt(3);
      check("banks kept", keep, mask_tab[i]);
      if (i < 2) begin
        tick_gap(g);
        check("refresh gap", g, i ? REFI_HOT : REFI_NORM);
      end
      @(posedge ref_clk_in);
      sref <= 1'b0;
      wt(3);
      check("all banks kept", keep, 8'hff);
    end
    check("notes left", notes.size(), 0);
    stop_test();
  end
endmodule
